// ==== include/host_cmd_regs.vh ====
// Constants for the host command parser: characters, timing, field widths
`ifndef HOST_CMD_REGS_VH
`define HOST_CMD_REGS_VH
`define CHR_START      8'h23
`define CHR_CR         8'h0d
`define CHR_LF         8'h0a
`define CHR_SPACE      8'h20
`define CLK_HZ         20000000
`define BAUD_DEFAULT   9600
`define BIT_CYCLES     (`CLK_HZ / `BAUD_DEFAULT)
`define BAUD_SEL_9600  4'h5
`define GRP_COMM       4'h1
`define SUB_MAIN       4'h0
`define CMD_BAUD       4'h0
`define MIN_CHARS      3'd2
`define MAX_CHARS      3'd7
`define FIFO_DEPTH     32
`define FIFO_AW        5
`define REPLY_LEN      5'd24
`endif

// ==== src/byte_fifo.v ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             sys_rst_i,
  // Fill side
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  // Drain side
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready_o  = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // byte_fifo
`default_nettype wire

// ==== src/ascii_host_command_parser.v ====
// Serial host command parser: UART, field split, framed replies
//
// Summary of operation
// - A pound sign starts a new command, discarding anything gathered.
// - Every transmitted message ends with carriage return then line feed.
// - Value characters must be 0-9 or uppercase A-F.
// - Fewer than two characters after the pound sign is not valid.
// - First character after the pound sign is the command group.
// - Second character is the command subgroup.
// - Third character is the command digit.
// - Fourth character is the setting; 5 on group 1 sub 0 cmd 0 is 9600.
// - Setting may be a four-digit hex string.
// - Line runs 9600 baud, 8 data bits, no parity, one stop bit.
// - A sign-on message is sent after reset without prompting.
// - Every reply starts with the pound sign.
// - Replies are Done when recognised, Error otherwise.
`timescale 1ns/1ps
`default_nettype none
`include "host_cmd_regs.vh"
module ascii_host_command_parser (
  // Clock and reset
  input  wire        clk_i,
  input  wire        sys_rst_i,
  // Serial link
  input  wire        rxd_i,
  output reg         txd_o,
  // Parsed command
  output reg         cmd_valid_o,
  output reg  [3:0]  cmd_group_o,
  output reg  [3:0]  cmd_subgroup_o,
  output reg  [3:0]  cmd_digit_o,
  output reg  [15:0] cmd_setting_o,
  output reg  [2:0]  cmd_len_o,
  output reg         cmd_error_o,
  // Baud selection code held from the last four-character baud command
  output reg  [3:0]  baud_sel_o
);
  localparam integer BIT_INT  = `BIT_CYCLES;
  localparam [15:0]  BIT_CNT  = BIT_INT[15:0];
  localparam [15:0]  HALF_CNT = BIT_CNT >> 1;

  // Receiver states
  localparam [1:0] RX_IDLE  = 2'd0;
  localparam [1:0] RX_START = 2'd1;
  localparam [1:0] RX_DATA  = 2'd2;
  localparam [1:0] RX_STOP  = 2'd3;

  reg [1:0]  rx_state;
  reg [15:0] rx_cnt;
  reg [2:0]  rx_bit;
  reg [7:0]  rx_shift;
  reg        rx_strobe;
  reg [7:0]  rx_byte;

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_state  <= RX_IDLE;
      rx_cnt    <= 16'h0000;
      rx_bit    <= 3'h0;
      rx_shift  <= 8'h00;
      rx_strobe <= 1'b0;
      rx_byte   <= 8'h00;
    end else begin
      rx_strobe <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          if (!rxd_i) begin
            rx_state <= RX_START;
            rx_cnt   <= 16'h0000;
          end
        end
        RX_START: begin
          if (rx_cnt == HALF_CNT) begin
            rx_cnt   <= 16'h0000;
            rx_bit   <= 3'h0;
            rx_state <= rxd_i ? RX_IDLE : RX_DATA;
          end else begin
            rx_cnt <= rx_cnt + 16'h0001;
          end
        end
        RX_DATA: begin
          if (rx_cnt == BIT_CNT - 16'h0001) begin
            rx_cnt   <= 16'h0000;
            rx_shift <= {rxd_i, rx_shift[7:1]};
            rx_bit   <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) begin
              rx_state <= RX_STOP;
            end
          end else begin
            rx_cnt <= rx_cnt + 16'h0001;
          end
        end
        default: begin
          if (rx_cnt == BIT_CNT - 16'h0001) begin
            rx_state <= RX_IDLE;
            // Framing errors drop the byte silently
            if (rxd_i) begin
              rx_strobe <= 1'b1;
              rx_byte   <= rx_shift;
            end
          end else begin
            rx_cnt <= rx_cnt + 16'h0001;
          end
        end
      endcase
    end
  end

  wire       is_digit = (rx_byte >= 8'h30) && (rx_byte <= 8'h39);
  wire       is_upper = (rx_byte >= 8'h41) && (rx_byte <= 8'h46);
  wire       is_hex   = is_digit | is_upper;
  wire [3:0] hex_val  = is_digit ? rx_byte[3:0] : (rx_byte[3:0] + 4'h9);

  reg        in_msg;
  reg [2:0]  nchars;
  reg        bad_char;
  reg [27:0] digits;
  reg        eval;

  // Message gathering
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      in_msg   <= 1'b0;
      nchars   <= 3'h0;
      bad_char <= 1'b0;
      digits   <= 28'h0000000;
      eval     <= 1'b0;
    end else begin
      eval <= 1'b0;
      if (rx_strobe) begin
        if (rx_byte == `CHR_START) begin
          in_msg   <= 1'b1;
          nchars   <= 3'h0;
          bad_char <= 1'b0;
          digits   <= 28'h0000000;
        end else if (rx_byte == `CHR_CR) begin
          if (in_msg) begin
            eval <= 1'b1;
          end
          in_msg <= 1'b0;
        end else if (in_msg) begin
          if (!is_hex) begin
            bad_char <= 1'b1;
          end
          // Overlong messages are marked bad rather than wrapping
          if (nchars == `MAX_CHARS) begin
            bad_char <= 1'b1;
          end else begin
            nchars <= nchars + 3'h1;
            digits <= {digits[23:0], hex_val};
          end
        end
      end
    end
  end

  // Left-align gathered digits: group in the top nibble
  reg [27:0] aligned;
  always @* begin
    aligned = digits << (5'd4 * (5'd7 - {2'b00, nchars}));
  end

  reg        reply_go;
  reg        reply_ok;

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_valid_o    <= 1'b0;
      cmd_group_o    <= 4'h0;
      cmd_subgroup_o <= 4'h0;
      cmd_digit_o    <= 4'h0;
      cmd_setting_o  <= 16'h0000;
      cmd_len_o      <= 3'h0;
      cmd_error_o    <= 1'b0;
      baud_sel_o     <= `BAUD_SEL_9600;
      reply_go       <= 1'b0;
      reply_ok       <= 1'b0;
    end else begin
      cmd_valid_o <= 1'b0;
      reply_go    <= 1'b0;
      if (eval) begin
        cmd_valid_o    <= 1'b1;
        reply_go       <= 1'b1;
        cmd_group_o    <= aligned[27:24];
        cmd_subgroup_o <= aligned[23:20];
        cmd_digit_o    <= aligned[19:16];
        if (nchars == 3'd7) begin
          cmd_setting_o <= aligned[15:0];
        end else begin
          cmd_setting_o <= {12'h000, aligned[15:12]};
        end
        cmd_len_o <= nchars;
        cmd_error_o <= bad_char | (nchars < `MIN_CHARS);
        reply_ok    <= ~bad_char & (nchars >= `MIN_CHARS);
        if (!bad_char && nchars == 3'd4 && aligned[27:24] == `GRP_COMM &&
            aligned[23:20] == `SUB_MAIN && aligned[19:16] == `CMD_BAUD) begin
          baud_sel_o <= aligned[15:12];
        end
      end
    end
  end

  // Reply text, selected by index
  localparam [1:0] MSG_SIGNON = 2'd0;
  localparam [1:0] MSG_DONE   = 2'd1;
  localparam [1:0] MSG_ERROR  = 2'd2;

  reg  [1:0] msg_sel;
  reg  [4:0] msg_idx;
  reg        msg_busy;
  reg  [7:0] msg_char;
  reg  [4:0] msg_len;

  always @* begin
    msg_char = 8'h00;
    case (msg_sel)
      MSG_DONE: msg_len = 5'd7;
      MSG_ERROR: msg_len = 5'd8;
      default: msg_len = 5'd8;
    endcase
    if (msg_idx == 5'd0) begin
      msg_char = `CHR_START;
    end else if (msg_idx == msg_len - 5'd2) begin
      msg_char = `CHR_CR;
    end else if (msg_idx == msg_len - 5'd1) begin
      msg_char = `CHR_LF;
    end else begin
      case (msg_sel)
        MSG_DONE: msg_char = (msg_idx == 5'd1) ? 8'h44 :
                             (msg_idx == 5'd2) ? 8'h6f :
                             (msg_idx == 5'd3) ? 8'h6e : 8'h65;
        MSG_ERROR: msg_char = (msg_idx == 5'd1) ? 8'h45 :
                              (msg_idx == 5'd4) ? 8'h6f : 8'h72;
        default: msg_char = (msg_idx == 5'd1) ? 8'h52 :
                            (msg_idx == 5'd2) ? 8'h65 :
                            (msg_idx == 5'd3) ? 8'h61 :
                            (msg_idx == 5'd4) ? 8'h64 : 8'h79;
      endcase
    end
  end

  // Reply loader; the FIFO absorbs replies while the line is busy
  wire       fifo_in_ready;
  wire [7:0] fifo_out_data;
  wire       fifo_out_valid;
  reg        tx_ready;
  reg        signon_pend;
  reg        pend_go;
  reg        pend_ok;

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      msg_sel     <= MSG_SIGNON;
      msg_idx     <= 5'd0;
      msg_busy    <= 1'b0;
      signon_pend <= 1'b1;
      pend_go     <= 1'b0;
      pend_ok     <= 1'b0;
    end else begin
      if (reply_go) begin
        pend_go <= 1'b1;
        pend_ok <= reply_ok;
      end
      if (msg_busy) begin
        if (fifo_in_ready) begin
          if (msg_idx == msg_len - 5'd1) begin
            msg_busy <= 1'b0;
          end
          msg_idx <= msg_idx + 5'd1;
        end
      end else if (signon_pend) begin
        signon_pend <= 1'b0;
        msg_busy    <= 1'b1;
        msg_sel     <= MSG_SIGNON;
        msg_idx     <= 5'd0;
      end else if (pend_go) begin
        pend_go  <= reply_go;
        msg_busy <= 1'b1;
        msg_sel  <= pend_ok ? MSG_DONE : MSG_ERROR;
        msg_idx  <= 5'd0;
      end
    end
  end

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_tx_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   (msg_char),
    .in_valid_i  (msg_busy),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (tx_ready)
  );

  // Transmitter: 10-bit frame of start, 8 data LSB first, stop
  reg [9:0]  tx_shift;
  reg [3:0]  tx_bits;
  reg [15:0] tx_cnt;

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      txd_o    <= 1'b1;
      tx_shift <= 10'h3ff;
      tx_bits  <= 4'h0;
      tx_cnt   <= 16'h0000;
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= 1'b0;
      if (tx_bits == 4'h0) begin
        txd_o <= 1'b1;
        if (fifo_out_valid && !tx_ready) begin
          tx_ready <= 1'b1;
          tx_shift <= {1'b1, fifo_out_data, 1'b0};
          tx_bits  <= 4'd10;
          tx_cnt   <= 16'h0000;
        end
      end else begin
        txd_o <= tx_shift[0];
        if (tx_cnt == BIT_CNT - 16'h0001) begin
          tx_cnt   <= 16'h0000;
          tx_shift <= {1'b1, tx_shift[9:1]};
          tx_bits  <= tx_bits - 4'h1;
        end else begin
          tx_cnt <= tx_cnt + 16'h0001;
        end
      end
    end
  end
endmodule // ascii_host_command_parser
`default_nettype wire

// ==== tb/parser_sva.sv ====
// Port assertions for the host command parser
`timescale 1ns/1ps
`default_nettype none
`include "host_cmd_regs.vh"
module parser_sva (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  // Serial link
  input wire logic        rxd_i,
  input wire logic        txd_o,
  // Parsed command
  input wire logic        cmd_valid_o,
  input wire logic [3:0]  cmd_group_o,
  input wire logic [3:0]  cmd_subgroup_o,
  input wire logic [3:0]  cmd_digit_o,
  input wire logic [15:0] cmd_setting_o,
  input wire logic [2:0]  cmd_len_o,
  input wire logic        cmd_error_o,
  input wire logic [3:0]  baud_sel_o
);
  localparam int BIT = `BIT_CYCLES;
  int low_run;
  int high_run;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Saturating high count, so the first frame after reset is not flagged
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_run  <= 0;
      high_run <= BIT;
    end else begin
      low_run  <= txd_o ? 0 : low_run + 1;
      high_run <= !txd_o ? 0 : (high_run >= BIT ? BIT : high_run + 1);
    end
  end
  a_valid_one_cycle: assert property (cmd_valid_o |=> !cmd_valid_o)
    else $error("command strobe longer than one cycle");
  a_valid_in_stop: assert property (cmd_valid_o |-> rxd_i && $past(rxd_i, 4))
    else $error("command strobe outside a stop bit");
  a_short_is_error: assert property (cmd_valid_o && cmd_len_o < 3'd2 |-> cmd_error_o)
    else $error("short command not flagged");
  a_fields_hold: assert property (!cmd_valid_o |-> $stable({cmd_group_o,
    cmd_subgroup_o, cmd_digit_o, cmd_setting_o, cmd_len_o}))
    else $error("fields moved without a command");
  a_baud_update: assert property (cmd_valid_o && !cmd_error_o
    && cmd_group_o == 4'h1 && cmd_subgroup_o == 4'h0 && cmd_digit_o == 4'h0
    && cmd_len_o == 3'd4 |-> ##[0:2] baud_sel_o == cmd_setting_o[3:0])
    else $error("baud code not stored");
  a_baud_only_cmd: assert property ($changed(baud_sel_o)
    |-> cmd_valid_o || $past(cmd_valid_o) || $past(cmd_valid_o, 2))
    else $error("baud code changed without a command");
  a_bit_whole_low: assert property ($rose(txd_o) |-> low_run % BIT == 0)
    else $error("low run not whole bits");
  a_stop_bit_high: assert property ($fell(txd_o) |-> high_run >= BIT)
    else $error("stop bit too short");
  a_sign_on: assert property ($fell(sys_rst_i) |-> ##[0:1000] !txd_o)
    else $error("no sign-on after reset");
endmodule // parser_sva
bind ascii_host_command_parser parser_sva chk (.clk_i, .sys_rst_i, .rxd_i,
  .txd_o, .cmd_valid_o, .cmd_group_o, .cmd_subgroup_o, .cmd_digit_o,
  .cmd_setting_o, .cmd_len_o, .cmd_error_o, .baud_sel_o);
`default_nettype wire

// ==== tb/host_model.sv ====
// Host end of the serial link: sends bytes, collects replies
`timescale 1ns/1ps
`default_nettype none
`include "host_cmd_regs.vh"
module host_model (
  // Clock
  input  wire logic clk_i,
  // Serial link
  output var  logic rxd_o,
  input  wire logic txd_i
);
  localparam int BIT = `BIT_CYCLES;
  logic [7:0] got[$];
  initial rxd_o = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      #1 rxd_o = fr[i];
      repeat (BIT) @(posedge clk_i);
    end
  endtask
  // mid-bit sampling; bad stop bit drops the byte
  always begin
    logic [7:0] b;
    @(negedge txd_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_i);
      b[i] = txd_i;
    end
    repeat (BIT) @(posedge clk_i);
    if (txd_i === 1'b1) got.push_back(b);
  end
endmodule // host_model
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the host command parser
`timescale 1ns/1ps
`default_nettype none
`include "host_cmd_regs.vh"
module tb;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  wire         rxd;
  wire         txd;
  wire         cmd_valid_o;
  wire  [3:0]  cmd_group_o;
  wire  [3:0]  cmd_subgroup_o;
  wire  [3:0]  cmd_digit_o;
  wire  [15:0] cmd_setting_o;
  wire  [2:0]  cmd_len_o;
  wire         cmd_error_o;
  wire  [3:0]  baud_sel_o;
  int          miscompares = 0;
  int          total_checks = 0;
  int          nval = 0;
  logic        er;
  logic [3:0]  baud = `BAUD_SEL_9600;
  logic [31:0] seed = 32'h5c;
  string       rep = "#Ready\r\n#Done\r\n#Error\r\n";
  ascii_host_command_parser dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .rxd_i(rxd), .txd_o(txd), .cmd_valid_o(cmd_valid_o),
    .cmd_group_o(cmd_group_o), .cmd_subgroup_o(cmd_subgroup_o),
    .cmd_digit_o(cmd_digit_o), .cmd_setting_o(cmd_setting_o),
    .cmd_len_o(cmd_len_o), .cmd_error_o(cmd_error_o),
    .baud_sel_o(baud_sel_o));
  host_model host (.clk_i(clk_i), .rxd_o(rxd), .txd_i(txd));
  initial forever #25 clk_i = ~clk_i;
  // Sampled mid-cycle, away from the launching edge
  always @(negedge clk_i) begin
    if (cmd_valid_o === 1'b1) begin
      nval++;
      er = cmd_error_o;
    end
  end
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic is_hex(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction
  function automatic logic [3:0] hv(input logic [7:0] c);
    return c <= 8'h39 ? 4'(c - 8'h30) : 4'(c - 8'h37);
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic run_cmd(input logic [7:0] c[$]);
    int   n;
    int   k;
    logic ok;
    n = c.size();
    k = nval;
    ok = n >= 2 && n <= 7;
    foreach (c[i]) ok = ok && is_hex(c[i]);
    host.send_byte(`CHR_START);
    foreach (c[i]) host.send_byte(c[i]);
    host.send_byte(`CHR_CR);
    for (int t = 0; t < 200 && nval == k; t++) @(posedge clk_i);
    #2;
    check(16'(nval - k), 16'h1);
    check(16'(er), 16'(!ok));
    check(16'(cmd_len_o), n > 7 ? 16'h7 : 16'(n));
    if (ok) begin
      check(16'(cmd_group_o), 16'(hv(c[0])));
      check(16'(cmd_subgroup_o), 16'(hv(c[1])));
      if (n >= 3) check(16'(cmd_digit_o), 16'(hv(c[2])));
      if (n == 7) check(cmd_setting_o, {hv(c[3]), hv(c[4]), hv(c[5]), hv(c[6])});
      if (n >= 4 && n < 7) check(16'(cmd_setting_o[3:0]), 16'(hv(c[3])));
      if (n == 4 && c[0] == 8'h31 && c[1] == 8'h30 && c[2] == 8'h30)
        baud = hv(c[3]);
    end
    repeat (3) @(posedge clk_i);
    #1 check(16'(baud_sel_o), 16'(baud));
  endtask
  initial begin
    logic [7:0] q[$];
    repeat (20) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    check(16'(baud_sel_o), 16'(`BAUD_SEL_9600));
    run_cmd('{8'h31, 8'h30, 8'h30, 8'h33});
    run_cmd('{8'h31, 8'h61});
    run_cmd('{8'h31});
    run_cmd('{8'h31, 8'h30, 8'h30, 8'h31, 8'h32, 8'h41, 8'h42});
    // Overlong setting is refused, length saturates
    run_cmd('{8'h31, 8'h30, 8'h30, 8'h35, 8'h31, 8'h32, 8'h33, 8'h34});
    for (int i = 0; i < 4; i++) begin
      seed = xorshift(seed);
      q.push_back(seed[3:0] < 4'ha ? 8'h30 + seed[3:0] : 8'h37 + seed[3:0]);
    end
    run_cmd(q);
    for (int t = 0; t < 400000 && host.got.size() < rep.len(); t++)
      @(posedge clk_i);
    for (int i = 0; i < rep.len(); i++)
      check(16'(host.got[i]), 16'(rep[i]));
    give_verdict();
  end
  // Watchdog: about fifty byte times covers every frame above
  initial begin
    repeat (50 * 10 * `BIT_CYCLES) @(posedge clk_i);
    miscompares++;
    give_verdict();
  end
endmodule // tb
`default_nettype wire
